/* File: src/pcrc_top.sv */
// Loop clock divider, lock status and regulator configuration block
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/100ps

module pcrc_top
   import pcrc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire pcrc_wb_req_t wb_req_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic special_mode_i,
   input wire logic in_lock_tol_i,
   input wire logic out_unlock_tol_i,
   input wire logic ref_lost_i,
   input wire logic osc_stable_i,
   output pcrc_clk_cfg_t clk_cfg_o,
   output pcrc_ctrl_t ctrl_o,
   output logic irq_o
);

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic req;
   logic wr_fire;
   logic [5:0] idx;
   logic [7:0] wbyte;
   logic ack_q;

   assign req = wb_req_i.cyc & wb_req_i.stb;
   assign idx = wb_req_i.adr[7:2];
   assign wbyte = wb_req_i.dat[7:0];
   // Writes land on the edge where the master sees ack; lane 0 only
   assign wr_fire = req & ack_q & wb_req_i.we & wb_req_i.sel[0];

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_q <= 1'b0;
      else
         ack_q <= req & ~ack_q;
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   logic write_protect_bit_q;
   logic loop_sel_q;
   logic osc_en_q;
   logic [5:0] mult_q;
   logic [1:0] osc_range_q;
   logic [3:0] reference_divider_q;
   logic [1:0] ref_range_q;
   logic [4:0] post_divider_q;
   logic lock_ie_q;
   logic [2:0] vreg_q;
   logic vreg_done_q;
   logic [1:0] osc2_q;
   logic cfg_open;
   logic vreg_ok;

   // Protected registers only move while unprotected and on loop clock
   assign cfg_open = ~write_protect_bit_q & loop_sel_q;
   // A blocked write does not use up the single write
   assign vreg_ok = (special_mode_i | ~vreg_done_q)
      & (wbyte[VREG_EXT_BIT] ^ wbyte[VREG_INT_BIT]);

   // Protection key
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         write_protect_bit_q <= 1'b0;
      else if (wr_fire && idx == IDX_WRITE_PROTECT_BIT)
         write_protect_bit_q <= (wbyte != WRITE_PROTECT_BIT_UNLOCK);
   end

   // Divider fields and clock select, all protected
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mult_q <= MULT_RST;
         osc_range_q <= OSC_RANGE_RST;
         reference_divider_q <= REFERENCE_DIVIDER_RST;
         ref_range_q <= REF_RANGE_RST;
         post_divider_q <= POST_DIVIDER_RST;
         loop_sel_q <= 1'b1;
         osc_en_q <= 1'b0;
      end
      else if (wr_fire && cfg_open)
      begin
         if (idx == IDX_MULT)
         begin
            mult_q <= wbyte[5:0];
            osc_range_q <= wbyte[RANGE_LSB +: 2];
         end
         if (idx == IDX_REFERENCE_DIVIDER)
         begin
            reference_divider_q <= wbyte[3:0];
            ref_range_q <= wbyte[RANGE_LSB +: 2];
         end
         if (idx == IDX_POST_DIVIDER)
            post_divider_q <= wbyte[4:0];
         if (idx == IDX_CLKSEL)
            loop_sel_q <= wbyte[CLKSEL_LOOP_BIT];
         if (idx == IDX_OSC1)
            osc_en_q <= wbyte[OSC1_EN_BIT];
      end
   end

   // Oscillator register two; frozen while the oscillator runs
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         osc2_q <= OSC2_RST;
      else if (wr_fire && idx == IDX_OSC2 && cfg_open && !osc_en_q)
      begin
         osc2_q[OSC2_AMP_BIT] <= wbyte[OSC2_AMP_BIT];
         osc2_q[OSC2_MRE_BIT] <= wbyte[OSC2_MRE_BIT];
      end
   end

   // Regulator control, write once in normal mode
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         vreg_q <= VREG_RST;
         vreg_done_q <= 1'b0;
      end
      else if (wr_fire && idx == IDX_VREG && vreg_ok)
      begin
         vreg_q <= wbyte[2:0];
         vreg_done_q <= 1'b1;
      end
   end

   // Lock interrupt enable
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         lock_ie_q <= 1'b0;
      else if (wr_fire && idx == IDX_INTEN)
         lock_ie_q <= wbyte[INTEN_LOCK_BIT];
   end

   // ----------------------------------------------------------------
   // Lock detection
   // ----------------------------------------------------------------
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic lock_q;
   logic lock_prev_q;
   logic stable_q;
   logic chg_q;
   logic osc1_wr;

   assign osc1_wr = wr_fire && idx == IDX_OSC1 && cfg_open;

   // Analogue detector levels come from another timing world
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end
      else
      begin
         sync1_q <= {osc_stable_i, ref_lost_i, out_unlock_tol_i,
                     in_lock_tol_i};
         sync2_q <= sync1_q;
      end
   end

   // Lock flag; lost reference and oscillator writes win over set
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         lock_q <= 1'b0;
      else if (sync2_q[2] || osc1_wr)
         lock_q <= 1'b0;
      else if (sync2_q[0])
         lock_q <= 1'b1;
      else if (sync2_q[1])
         lock_q <= 1'b0;
   end

   // Oscillator stable flag follows the detector unless just written
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         stable_q <= 1'b0;
      else
         stable_q <= sync2_q[3] & ~osc1_wr;
   end

   // Sticky change flag; a new change beats a clear in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         lock_prev_q <= 1'b0;
         chg_q <= 1'b0;
      end
      else
      begin
         lock_prev_q <= lock_q;
         if (lock_q != lock_prev_q)
            chg_q <= 1'b1;
         else if (wr_fire && idx == IDX_FLAGS && wbyte[FLAGS_CHG_BIT])
            chg_q <= 1'b0;
      end
   end

   // Interrupt request only while enabled
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= chg_q & lock_ie_q;
   end

   // ----------------------------------------------------------------
   // Divider ratios and control outputs
   // ----------------------------------------------------------------
   // Ratios are registered so the analogue side sees clean levels
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         clk_cfg_o <= '0;
      else
      begin
         clk_cfg_o.ref_from_osc <= osc_en_q;
         clk_cfg_o.ref_div <= {1'b0, reference_divider_q} + 5'h01;
         clk_cfg_o.vco_mult <= {1'b0, mult_q, 1'b0} + 8'h02;
         clk_cfg_o.fb_div <= {1'b0, mult_q} + 7'h01;
         clk_cfg_o.loop_div <= lock_q
            ? {1'b0, post_divider_q} + 6'h01 : UNLOCKED_DIV;
         clk_cfg_o.bus_from_loop <= loop_sel_q;
         clk_cfg_o.bus_div <= BUS_FROM_LOOP_DIV;
         clk_cfg_o.ref_range <= ref_range_q;
         clk_cfg_o.osc_range <= osc_range_q;
      end
   end

   // Regulator and oscillator control levels
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ctrl_o <= '0;
      else
         ctrl_o <= {vreg_q[VREG_CORE_BIT],
            vreg_q[VREG_EXT_BIT], vreg_q[VREG_INT_BIT],
            osc_en_q, osc2_q[OSC2_AMP_BIT], osc2_q[OSC2_MRE_BIT]};
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [7:0] rd_byte;

   // Unmapped words read as zero and still acknowledge
   always_comb
   begin
      rd_byte = 8'h00;
      unique case (idx)
         IDX_MULT: rd_byte = {osc_range_q, mult_q};
         IDX_REFERENCE_DIVIDER: rd_byte = {ref_range_q, 2'h0, reference_divider_q};
         IDX_POST_DIVIDER: rd_byte = {3'h0, post_divider_q};
         IDX_CLKSEL: rd_byte = {loop_sel_q, 7'h00};
         IDX_INTEN: rd_byte = {3'h0, lock_ie_q, 4'h0};
         IDX_FLAGS: rd_byte = {3'h0, chg_q, lock_q, stable_q, 2'h0};
         IDX_VREG: rd_byte = {5'h00, vreg_q};
         IDX_OSC1: rd_byte = {osc_en_q, 7'h00};
         IDX_WRITE_PROTECT_BIT: rd_byte = {7'h00, write_protect_bit_q};
         IDX_OSC2: rd_byte = {6'h00, osc2_q};
         default: rd_byte = 8'h00;
      endcase
   end

   // Read data captured with the request so it is steady under ack
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h0000_0000;
      else if (req && !ack_q)
         wb_dat_o <= {24'h00_0000, rd_byte};
   end

   assign wb_ack_o = ack_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking ast_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence vreg_second_write;
      vreg_done_q && !special_mode_i && wr_fire && idx == IDX_VREG;
   endsequence
   sequence lock_edge;
      lock_ie_q && (lock_q != lock_prev_q) ##1 lock_ie_q;
   endsequence

   AST_VREG_ONCE: assert property (vreg_second_write
      |=> $stable(vreg_q))
      else $error("regulator changed after its single write");
   AST_VREG_PAIR: assert property (wr_fire && idx == IDX_VREG
      && wbyte[VREG_EXT_BIT] == wbyte[VREG_INT_BIT] |=> $stable(vreg_q))
      else $error("regulator accepted an illegal select pair");
   AST_VREG_OUT: assert property (!rst_i
      |=> ctrl_o.core_domain_regulator_enable == $past(vreg_q[VREG_CORE_BIT]))
      else $error("core domain enable does not follow its bit");
   AST_OSC2_GATE: assert property (wr_fire && idx == IDX_OSC2
      && (write_protect_bit_q || !loop_sel_q) |=> $stable(osc2_q))
      else $error("oscillator register two written while locked out");
   AST_OSC2_FROZEN: assert property (osc_en_q
      && !(wr_fire && idx == IDX_OSC1) |=> $stable(osc2_q))
      else $error("amplitude or monitor bit moved with oscillator on");
   AST_UNLOCK_DIV: assert property (!rst_i && !lock_q
      |=> clk_cfg_o.loop_div == UNLOCKED_DIV)
      else $error("unlocked output divider is not four");
   AST_REF_LOST: assert property (sync2_q[2] |=> !lock_q)
      else $error("lock reported with reference lost");
   AST_OSC1_CLR: assert property (osc1_wr
      |=> !lock_q && !stable_q)
      else $error("oscillator write left lock or stable set");
   AST_LOCK_IRQ: assert property (lock_edge |=> irq_o)
      else $error("lock change raised no interrupt");
   AST_WRITE_PROTECT_BIT_KEY: assert property (wr_fire && idx == IDX_WRITE_PROTECT_BIT
      |=> write_protect_bit_q == ($past(wbyte) != WRITE_PROTECT_BIT_UNLOCK))
      else $error("protection bit did not follow the key");
   AST_SYNC_LAT: assert property ($rose(in_lock_tol_i)
      ##1 in_lock_tol_i[*2] |-> sync2_q[0])
      else $error("lock detector level not synchronised in two cycles");

endmodule

/* File: common/pcrc_pkg.sv */
// Package of constants and carrier types for the loop clock configuration
package pcrc_pkg;

   // Register word indices; byte address is four times the index
   localparam logic [5:0] IDX_MULT = 6'h04;
   localparam logic [5:0] IDX_REFERENCE_DIVIDER = 6'h05;
   localparam logic [5:0] IDX_POST_DIVIDER = 6'h06;
   localparam logic [5:0] IDX_CLKSEL = 6'h07;
   localparam logic [5:0] IDX_INTEN = 6'h08;
   localparam logic [5:0] IDX_FLAGS = 6'h09;
   localparam logic [5:0] IDX_VREG = 6'h19;
   localparam logic [5:0] IDX_OSC1 = 6'h1A;
   localparam logic [5:0] IDX_WRITE_PROTECT_BIT = 6'h1B;
   localparam logic [5:0] IDX_OSC2 = 6'h1E;

   // Field positions
   localparam int VREG_CORE_BIT = 2;
   localparam int VREG_EXT_BIT = 1;
   localparam int VREG_INT_BIT = 0;
   localparam int OSC2_MRE_BIT = 1;
   localparam int OSC2_AMP_BIT = 0;
   localparam int OSC1_EN_BIT = 7;
   localparam int CLKSEL_LOOP_BIT = 7;
   localparam int INTEN_LOCK_BIT = 4;
   localparam int FLAGS_CHG_BIT = 4;
   localparam int FLAGS_LOCK_BIT = 3;
   localparam int FLAGS_STABLE_BIT = 2;
   localparam int RANGE_LSB = 6;

   // Reset values and key codes
   localparam logic [5:0] MULT_RST = 6'h18;
   localparam logic [1:0] OSC_RANGE_RST = 2'h1;
   localparam logic [3:0] REFERENCE_DIVIDER_RST = 4'h0;
   localparam logic [1:0] REF_RANGE_RST = 2'h0;
   localparam logic [4:0] POST_DIVIDER_RST = 5'h03;
   localparam logic [2:0] VREG_RST = 3'h5;
   localparam logic [1:0] OSC2_RST = 2'h0;
   localparam logic [7:0] WRITE_PROTECT_BIT_UNLOCK = 8'h26;
   localparam logic [5:0] UNLOCKED_DIV = 6'h04;
   localparam logic [5:0] BUS_FROM_LOOP_DIV = 6'h02;
   localparam int SYNC_STAGES = 2;

   // Classic Wishbone request from the master
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } pcrc_wb_req_t;

   // Divider ratios handed to the analogue clock generator
   typedef struct packed {
      logic ref_from_osc;
      logic [4:0] ref_div;
      logic [7:0] vco_mult;
      logic [6:0] fb_div;
      logic [5:0] loop_div;
      logic bus_from_loop;
      logic [5:0] bus_div;
      logic [1:0] ref_range;
      logic [1:0] osc_range;
   } pcrc_clk_cfg_t;

   // Regulator and oscillator control levels
   typedef struct packed {
      logic core_domain_regulator_enable;
      logic io_loop_external_transistor;
      logic io_loop_internal_transistor;
      logic oscillator_enable;
      logic oscillator_amplitude_mode;
      logic clock_monitor_reset_enable;
   } pcrc_ctrl_t;

endpackage

/* File: test/pcrc_tb_top.sv */
// Self-checking testbench for the loop clock configuration block
`timescale 1ns/100ps

module pcrc_tb_top;
   import pcrc_pkg::*;

   typedef struct packed {
      logic [5:0] idx;
      logic [7:0] wdat;
      logic [7:0] exp;
   } pcrc_row_t;

   logic clk_i;
   logic rst_i;
   pcrc_wb_req_t wb_req_i;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic special_mode_i;
   logic in_lock_tol_i;
   logic out_unlock_tol_i;
   logic ref_lost_i;
   logic osc_stable_i;
   pcrc_clk_cfg_t clk_cfg_o;
   pcrc_ctrl_t ctrl_o;
   logic irq_o;
   int fails;
   int tests_run;
   logic [7:0] rd;
   pcrc_row_t rows [5];

   pcrc_top DUT (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_req_i(wb_req_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .special_mode_i(special_mode_i),
      .in_lock_tol_i(in_lock_tol_i),
      .out_unlock_tol_i(out_unlock_tol_i),
      .ref_lost_i(ref_lost_i),
      .osc_stable_i(osc_stable_i),
      .clk_cfg_o(clk_cfg_o),
      .ctrl_o(ctrl_o),
      .irq_o(irq_o)
   );

   // ----------------------------------------
   // Clock and helpers
   // ----------------------------------------
   // 25 MHz bus clock
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // Verdict and end of run
   task automatic test_done();
      if (fails == 0 && tests_run > 0)
      begin
         $display("== PASSED ==");
      end
      else
      begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Four-state compare so an unknown never passes
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Classic single cycle; request held until ack is sampled high
   task automatic wb(input logic we, input logic [5:0] idx,
                     input logic [7:0] wdat);
      int n;
      n = 0;
      wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1,
                    adr: {idx, 2'b00}, dat: {24'h00_0000, wdat}};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 20)
      begin
         @(posedge clk_i);
         n++;
      end
      rd = wb_dat_o[7:0];
      chk(wb_dat_o[31:8], 0);
      wb_req_i <= '0;
      if (n >= 20)
      begin
         fails++;
         test_done();
      end
      // Idle cycles keep ack apart and let registered outputs settle
      repeat (2) @(posedge clk_i);
   endtask

   // Read a register and compare its low byte
   task automatic rc(input logic [5:0] idx, input logic [7:0] exp);
      wb(1'b0, idx, 8'h00);
      chk(rd, exp);
   endtask

   // Lock detector levels, then enough edges for sync and flag update
   task automatic det(input logic lk, input logic ul, input logic lost);
      in_lock_tol_i <= lk;
      out_unlock_tol_i <= ul;
      ref_lost_i <= lost;
      repeat (8) @(posedge clk_i);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      fails = 0;
      tests_run = 0;
      rst_i = 1'b1;
      wb_req_i = '0;
      special_mode_i = 1'b0;
      in_lock_tol_i = 1'b0;
      out_unlock_tol_i = 1'b0;
      ref_lost_i = 1'b0;
      osc_stable_i = 1'b0;
      rows[0] = '{IDX_MULT, 8'h45, 8'h45};
      rows[1] = '{IDX_REFERENCE_DIVIDER, 8'hFF, 8'hCF};
      rows[2] = '{IDX_POST_DIVIDER, 8'hFF, 8'h1F};
      rows[3] = '{IDX_INTEN, 8'h10, 8'h10};
      rows[4] = '{6'h30, 8'hAA, 8'h00};
      repeat (12) @(posedge clk_i);
      chk(wb_ack_o, 0);
      chk(clk_cfg_o, 0);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      // Reset configuration of the dividers and regulator
      chk(clk_cfg_o.vco_mult, 8'h32);
      chk(clk_cfg_o.fb_div, 7'h19);
      chk(clk_cfg_o.ref_div, 5'h01);
      chk(clk_cfg_o.loop_div, 6'h04);
      chk(clk_cfg_o.bus_div, 6'h02);
      chk(ctrl_o.core_domain_regulator_enable, 1);
      chk(ctrl_o.io_loop_internal_transistor, 1);
      rc(IDX_MULT, 8'h58);
      rc(IDX_POST_DIVIDER, 8'h03);
      rc(IDX_CLKSEL, 8'h80);
      rc(IDX_VREG, 8'h05);
      rc(IDX_OSC2, 8'h00);
      // Table of plain write and read-back cases, unmapped last
      foreach (rows[i])
      begin
         wb(1'b1, rows[i].idx, rows[i].wdat);
         rc(rows[i].idx, rows[i].exp);
      end
      chk(clk_cfg_o.vco_mult, 8'h0C);
      chk(clk_cfg_o.fb_div, 7'h06);
      chk(clk_cfg_o.ref_div, 5'h10);
      chk({clk_cfg_o.ref_range, clk_cfg_o.osc_range}, 4'hD);
      chk(clk_cfg_o.loop_div, 6'h04);
      // Regulator: illegal pairs blocked, then one write lands in normal mode and another only in special mode
      wb(1'b1, IDX_VREG, 8'h03);
      rc(IDX_VREG, 8'h05);
      wb(1'b1, IDX_VREG, 8'h00);
      rc(IDX_VREG, 8'h05);
      wb(1'b1, IDX_VREG, 8'h02);
      rc(IDX_VREG, 8'h02);
      chk(ctrl_o.io_loop_external_transistor, 1);
      chk(ctrl_o.core_domain_regulator_enable, 0);
      wb(1'b1, IDX_VREG, 8'h05);
      rc(IDX_VREG, 8'h02);
      special_mode_i <= 1'b1;
      wb(1'b1, IDX_VREG, 8'h05);
      rc(IDX_VREG, 8'h05);
      special_mode_i <= 1'b0;
      // Oscillator register two: frozen bits and protection
      wb(1'b1, IDX_OSC2, 8'h03);
      chk(ctrl_o.oscillator_amplitude_mode, 1);
      chk(ctrl_o.clock_monitor_reset_enable, 1);
      wb(1'b1, IDX_OSC1, 8'h80);
      chk(clk_cfg_o.ref_from_osc, 1);
      wb(1'b1, IDX_OSC2, 8'h00);
      rc(IDX_OSC2, 8'h03);
      wb(1'b1, IDX_WRITE_PROTECT_BIT, 8'h11);
      rc(IDX_WRITE_PROTECT_BIT, 8'h01);
      wb(1'b1, IDX_OSC1, 8'h00);
      chk(ctrl_o.oscillator_enable, 1);
      wb(1'b1, IDX_WRITE_PROTECT_BIT, 8'h26);
      rc(IDX_WRITE_PROTECT_BIT, 8'h00);
      wb(1'b1, IDX_OSC1, 8'h00);
      wb(1'b1, IDX_OSC2, 8'h00);
      rc(IDX_OSC2, 8'h00);
      // Lock, interrupt on each change, lost reference
      osc_stable_i <= 1'b1;
      det(1'b1, 1'b0, 1'b0);
      chk(clk_cfg_o.loop_div, 6'h20);
      chk(irq_o, 1);
      rc(IDX_FLAGS, 8'h1C);
      wb(1'b1, IDX_FLAGS, 8'h10);
      chk(irq_o, 0);
      det(1'b1, 1'b0, 1'b1);
      chk(clk_cfg_o.loop_div, 6'h04);
      chk(irq_o, 1);
      wb(1'b1, IDX_FLAGS, 8'h10);
      det(1'b1, 1'b0, 1'b0);
      det(1'b0, 1'b1, 1'b0);
      chk(clk_cfg_o.loop_div, 6'h04);
      wb(1'b1, IDX_INTEN, 8'h00);
      wb(1'b1, IDX_FLAGS, 8'h10);
      det(1'b1, 1'b0, 1'b0);
      chk(irq_o, 0);
      rc(IDX_FLAGS, 8'h1C);
      // Held lock is dropped by an oscillator register one write
      det(1'b0, 1'b0, 1'b0);
      wb(1'b1, IDX_OSC1, 8'h00);
      chk(clk_cfg_o.loop_div, 6'h04);
      rc(IDX_FLAGS, 8'h14);
      // Leaving loop select locks out register two until reset
      wb(1'b1, IDX_CLKSEL, 8'h00);
      chk(clk_cfg_o.bus_from_loop, 0);
      wb(1'b1, IDX_OSC2, 8'h03);
      rc(IDX_OSC2, 8'h00);
      // Second reset restores the single regulator write
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b1, IDX_VREG, 8'h01);
      wb(1'b1, IDX_VREG, 8'h02);
      rc(IDX_VREG, 8'h01);
      chk(ctrl_o.core_domain_regulator_enable, 0);
      test_done();
   end

endmodule
